// ---- pkg/comparator_control_pkg.sv ----
// Package: register map, field positions and timing for the comparator control
package comparator_control_pkg;

  // Register byte address (single control register word)
  localparam logic [7:0] comparator_control_0_addr = 8'h00;
  localparam logic [7:0] ctrl_reset_val            = 8'h00;

  // Field positions in the control register
  localparam int enable_bit   = 7;
  localparam int pin_en_bit   = 6;
  localparam int polarity_bit = 5;
  localparam int speed_bit    = 4;
  localparam logic [7:0] ctrl_writable_mask = 8'hf0;

  // Initialization hold after enabling, in bus clock cycles
  localparam int init_hold_cycles = 127;
  localparam int hold_cnt_w       = 7;

  // AXI4-Lite responses
  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // Enable state machine states
  typedef enum logic [2:0] {
    st_off  = 3'h1,
    st_init = 3'h2,
    st_run  = 3'h4
  } cmp_state_t;

endpackage

// ---- rtl/comparator_hold_path.sv ----
// Output path of the comparator: input synchroniser and hold latch
module comparator_hold_path
  import comparator_control_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic raw_in,
  input  wire logic track,
  output logic      held_out
);

  logic sync1_ff;
  logic sync2_ff;
  logic nxt_held;

  // Two-stage synchroniser for the asynchronous comparator result
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end

  // Follow the result only while tracking, otherwise keep last state
  assign nxt_held = track ? sync2_ff : held_out;

  // Held output register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      held_out <= 1'b0;
    end else begin
      held_out <= nxt_held;
    end
  end

endmodule // comparator_hold_path

// ---- rtl/comparator_control.sv ----
// Comparator control block with AXI4-Lite register access
// Summary of operation
// - Bit 7 enables the comparator and routes its inputs to the filters.
// - After enable is set the output path holds its state for 127 cycles.
// - Clearing enable keeps the last comparator output state unchanged.
// - Bit 6 drives the comparator result onto the external output pin.
// - Bit 5 inverts the result seen on the external output pin.
// - Bit 4 selects the high-speed input filter, else the low-speed one.
// - The control register can be read and written at any time.
//
// Chosen here: the address map and the AXI4-Lite slave port.
module comparator_control
  import comparator_control_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        comparator_raw,
  output logic             comparator_enable,
  output logic             input_filter_speed_select,
  output logic             comparator_output_value,
  output logic             comparator_output_pin,
  output logic             comparator_output_pin_oe
);

  logic [7:0]            ctrl_ff;
  logic [7:0]            nxt_ctrl;
  logic                  aw_got_ff;
  logic                  w_got_ff;
  logic [7:0]            awaddr_ff;
  logic [31:0]           wdata_ff;
  logic                  wstrb0_ff;
  cmp_state_t            state_ff;
  cmp_state_t            nxt_state;
  logic [hold_cnt_w-1:0] cnt_ff;
  logic [hold_cnt_w-1:0] nxt_cnt;
  logic                  held_value;
  logic                  track;

  // Address match for the single control register
  function automatic logic hit(input logic [7:0] a);
    return a[7:2] == comparator_control_0_addr[7:2];
  endfunction

  // Write channel handshakes and commit
  wire aw_take  = s_axi_awvalid && s_axi_awready;
  wire w_take   = s_axi_wvalid && s_axi_wready;
  wire have_aw  = aw_got_ff || aw_take;
  wire have_w   = w_got_ff || w_take;
  wire [7:0] wa = aw_got_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0] wd = w_got_ff ? wdata_ff : s_axi_wdata;
  wire ws0      = w_got_ff ? wstrb0_ff : s_axi_wstrb[0];
  wire commit   = have_aw && have_w && !s_axi_bvalid;
  wire wr_hit   = commit && hit(wa);
  wire ctrl_we  = wr_hit && ws0;
  wire ar_take  = s_axi_arvalid && s_axi_arready;
  wire [31:0] rd_word = {24'h0, ctrl_ff & ctrl_writable_mask};
  // Read address decode
  wire rd_hit   = hit(s_axi_araddr);

  // Writable bits only, low nibble never stored
  assign nxt_ctrl = ctrl_we ? (wd[7:0] & ctrl_writable_mask)
                            : ctrl_ff;

  // Write address and data capture, response generation
  // Ready pulses for one cycle, so a held valid is never taken twice
  always_ff @(posedge clk) begin
    if (!resetn) begin
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      awaddr_ff     <= 8'h00;
      wdata_ff      <= 32'h0;
      wstrb0_ff     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= resp_okay;
    end else begin
      if (aw_take) awaddr_ff <= s_axi_awaddr;
      if (w_take) begin
        wdata_ff  <= s_axi_wdata;
        wstrb0_ff <= s_axi_wstrb[0];
      end
      aw_got_ff <= commit ? 1'b0 : have_aw;
      w_got_ff  <= commit ? 1'b0 : have_w;
      s_axi_awready <= !have_aw && !commit && !s_axi_bvalid
                       && !s_axi_awready;
      s_axi_wready  <= !have_w && !commit && !s_axi_bvalid
                       && !s_axi_wready;
      if (commit) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= hit(wa) ? resp_okay : resp_slverr;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one-cycle registered answer
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= resp_okay;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_hit ? rd_word : 32'h0;
        s_axi_rresp  <= rd_hit ? resp_okay : resp_slverr;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Control register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_ff <= ctrl_reset_val;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Enable sequencing: off, initialization hold, running
  // Dropping enable mid-hold returns to off with the output still frozen
  wire en_next = nxt_ctrl[enable_bit];

  // Next state and hold count
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      st_off: begin
        if (en_next) begin
          nxt_state = st_init;
          nxt_cnt   = hold_cnt_w'(init_hold_cycles - 1);
        end
      end
      st_init: begin
        if (!en_next) begin
          nxt_state = st_off;
        end else if (cnt_ff == '0) begin
          nxt_state = st_run;
        end else begin
          nxt_cnt = cnt_ff - hold_cnt_w'(1);
        end
      end
      st_run: begin
        if (!en_next) nxt_state = st_off;
      end
      default: begin
        nxt_state = st_off;
        nxt_cnt   = '0;
      end
    endcase
  end

  // State and hold counter registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_ff <= st_off;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // Output path tracks only once running; held in hold and off states
  assign track = (state_ff == st_run);

  comparator_hold_path u_hold (
    .clk      (clk),
    .resetn   (resetn),
    .raw_in   (comparator_raw),
    .track    (track),
    .held_out (held_value)
  );

  // Field taps and pin level toward the analog core and the pin
  wire en_bit    = ctrl_ff[enable_bit];
  wire pin_bit   = ctrl_ff[pin_en_bit];
  wire inv_bit   = ctrl_ff[polarity_bit];
  wire speed_sel = ctrl_ff[speed_bit];
  wire pin_level = held_value ^ inv_bit;

  // Registered outputs toward the analog core and the pin
  always_ff @(posedge clk) begin
    if (!resetn) begin
      comparator_enable         <= 1'b0;
      input_filter_speed_select <= 1'b0;
      comparator_output_value   <= 1'b0;
      comparator_output_pin     <= 1'b0;
      comparator_output_pin_oe  <= 1'b0;
    end else begin
      comparator_enable         <= en_bit;
      input_filter_speed_select <= speed_sel;
      comparator_output_value   <= held_value;
      comparator_output_pin     <= pin_level;
      comparator_output_pin_oe  <= pin_bit;
    end
  end

endmodule // comparator_control

// ---- testbench/comparator_model.sv ----
// Behavioural analog comparator core driving its raw result
module comparator_model (
  input  wire logic clk,
  input  wire logic level,
  output logic      comparator_raw = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Result settles one clock after the analog inputs cross
  always @(posedge clk) comparator_raw <= level;
endmodule // comparator_model

// ---- testbench/comparator_control_checker.sv ----
// Checker: bus handshake and output path timing of comparator control
module comparator_control_checker (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        comparator_enable,
  input wire logic        input_filter_speed_select,
  input wire logic        comparator_output_value,
  input wire logic        comparator_output_pin_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [7:0] hold_cnt_ff;
  // Cycles spent enabled, saturating
  always_ff @(posedge clk) begin
    if (!resetn || !comparator_enable) hold_cnt_ff <= 8'h00;
    else if (hold_cnt_ff != 8'hff) hold_cnt_ff <= hold_cnt_ff + 8'h01;
  end
  write_resp_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write response late");
  read_resp_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  write_busy_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("aw busy");
  read_busy_a: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("ar busy");
  zero_bits_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[3:0] == 4'h0 && s_axi_rdata[31:8] == 24'h0)
    else $error("unused bits set");
  init_hold_a: assert property (
    comparator_enable && hold_cnt_ff < 8'h7f
    |=> $stable(comparator_output_value)) else $error("moved in hold");
  off_freeze_a: assert property (
    !comparator_enable [*3] |=> $stable(comparator_output_value))
    else $error("moved while off");
  cfg_write_a: assert property (
    $past(resetn) && ($changed(comparator_enable)
    || $changed(comparator_output_pin_oe)
    || $changed(input_filter_speed_select))
    |-> s_axi_bvalid || $past(s_axi_bvalid)) else $error("setting drift");
endmodule // comparator_control_checker

bind comparator_control comparator_control_checker chk (.clk, .resetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rdata, .comparator_enable, .input_filter_speed_select,
  .comparator_output_value, .comparator_output_pin_oe);

// ---- testbench/comparator_control_tb.sv ----
// Testbench: register access and comparator output path of the control block
module comparator_control_tb
  import comparator_control_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, resetn = 1'b0, raw_level = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, comparator_raw, comparator_enable;
  logic        input_filter_speed_select, comparator_output_value;
  logic        comparator_output_pin, comparator_output_pin_oe;
  int          error_cnt = 0, compares = 0;
  comparator_control dut (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .comparator_raw, .comparator_enable, .input_filter_speed_select,
    .comparator_output_value, .comparator_output_pin, .comparator_output_pin_oe);
  comparator_model far_side (.clk, .level(raw_level), .comparator_raw);
  // Bus clock
  initial forever #5 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata; r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask
  // Reset value, dead low bits and the field outputs
  task automatic reg_test();
    rd(comparator_control_0_addr);
    check(d, 32'h0);
    check(r, resp_okay);
    wr(comparator_control_0_addr, 32'hffff_ffff);
    rd(comparator_control_0_addr);
    check(d, 32'hf0);
    check({comparator_enable, input_filter_speed_select,
      comparator_output_pin_oe}, 32'h7);
    wr(comparator_control_0_addr, 32'h0f);
    rd(comparator_control_0_addr);
    check({d[7:0], comparator_enable, input_filter_speed_select}, 32'h0);
  endtask
  // Unmapped word answers with an error and changes nothing
  task automatic bad_addr_test();
    wr(8'h04, 32'h80);
    check(r, resp_slverr);
    rd(8'h04);
    check(d, 32'h0);
    check(r, resp_slverr);
    check(comparator_enable, 1'b0);
  endtask
  // Output path frozen through the start-up hold, then tracks
  task automatic hold_test();
    raw_level <= 1'b1;
    wr(comparator_control_0_addr, 32'h80);
    repeat (init_hold_cycles) @(posedge clk);
    check(comparator_output_value, 1'b0);
    @(posedge clk);
    check(comparator_output_value, 1'b1);
  endtask
  // Pin driven and inverted on request
  task automatic pol_test();
    wr(comparator_control_0_addr, 32'he0);
    check({comparator_output_pin_oe, comparator_output_pin}, 32'h2);
    wr(comparator_control_0_addr, 32'hc0);
    check({comparator_output_pin_oe, comparator_output_pin}, 32'h3);
  endtask
  // Disable keeps the last result; re-enable holds again
  task automatic off_test();
    wr(comparator_control_0_addr, 32'h40);
    raw_level <= 1'b0;
    repeat (20) @(posedge clk);
    check({comparator_output_value, comparator_output_pin}, 32'h3);
    wr(comparator_control_0_addr, 32'h80);
    repeat (init_hold_cycles) @(posedge clk);
    check(comparator_output_value, 1'b1);
    @(posedge clk);
    check(comparator_output_value, 1'b0);
  endtask
  // Hang guard
  initial begin
    #20000;
    error_cnt++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    reg_test();
    bad_addr_test();
    hold_test();
    pol_test();
    off_test();
    report_and_stop();
  end
endmodule // comparator_control_tb
